// ### hdl/eft_pkg.sv
package eft_pkg;

    // Register offsets
    localparam logic [7:0]  EXPOSURE_LOW_ADDR      = 8'h0e;
    localparam logic [7:0]  EXPOSURE_HIGH_ADDR     = 8'h0f;
    localparam logic [7:0]  FRAME_LENGTH_LOW_ADDR  = 8'h10;
    localparam logic [7:0]  FRAME_LENGTH_HIGH_ADDR = 8'h11;

    // Reset values
    localparam logic [15:0] EXPOSURE_RESET         = 16'h0064;
    localparam logic [7:0]  FRAME_LENGTH_LOW_RESET = 8'h20;
    localparam logic [7:0]  FRAME_LENGTH_HIGH_RESET = 8'hd1;

    // Timing
    localparam int          CLK_SYS_HZ             = 20_000_000;
    localparam int          CLK_SYS_PERIOD_NS      = 1_000_000_000 / CLK_SYS_HZ;
    localparam logic [16:0] EXPOSURE_HEADROOM      = 17'h00b00;
    localparam logic [15:0] COUNTER_LAST           = 16'hffff;

    // Pixel format and array layout
    localparam int          PIXEL_BITS             = 6;
    localparam logic [5:0]  PIXEL_WHITE            = 6'h3f;
    localparam int          PIXEL_ADDR_BITS        = 8;
    localparam logic [7:0]  PIXEL_ADDR_FIRST       = 8'h00;
    localparam logic [7:0]  PIXEL_ADDR_LAST        = 8'hff;

    // Brightest-pixel target window for the gain loop
    localparam logic [5:0]  GAIN_TARGET_LOW        = 6'h34;
    localparam logic [5:0]  GAIN_TARGET_HIGH       = 6'h3a;
    localparam int          GAIN_STEP_SHIFT        = 4;

endpackage

// ### hdl/eft_agc_if.sv
`timescale 1ns/1ps
interface eft_agc_if;
    import eft_pkg::*;

    logic                  frame_tick;
    logic [PIXEL_BITS-1:0] max_pixel;
    logic [15:0]           shutter_limit;
    logic [15:0]           shutter;

    modport ctrl (
        output frame_tick,
        output max_pixel,
        output shutter_limit,
        input  shutter
    );

    modport agc (
        input  frame_tick,
        input  max_pixel,
        input  shutter_limit,
        output shutter
    );
endinterface

// ### hdl/eft_gain_loop.sv
`timescale 1ns/1ps
module eft_gain_loop
    import eft_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic ce,
    eft_agc_if.agc    agc
);

    logic [15:0] step;
    logic [16:0] raised;
    logic [15:0] lowered;
    logic [15:0] next_shutter;

    // Step is one sixteenth of the present value
    assign step    = agc.shutter >> GAIN_STEP_SHIFT; // RULE6
    assign raised  = {1'b0, agc.shutter} + {1'b0, step};
    assign lowered = agc.shutter - step;

    always_comb begin
        next_shutter = agc.shutter;
        if (agc.max_pixel < GAIN_TARGET_LOW) begin // RULE3
            next_shutter = raised[16] ? 16'hffff : raised[15:0];
        end else if (agc.max_pixel > GAIN_TARGET_HIGH) begin // RULE3
            next_shutter = lowered;
        end
        if (next_shutter > agc.shutter_limit) begin // RULE7
            next_shutter = agc.shutter_limit;
        end
        if (next_shutter == 16'h0000) begin
            next_shutter = 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            agc.shutter <= EXPOSURE_RESET; // RULE4
        end else if (ce && agc.frame_tick) begin
            agc.shutter <= next_shutter; // RULE6
        end
    end

endmodule

// ### hdl/eft_exposure_frame_timing.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Each dumped pixel is six bits, zero black, 63 white.
// RULE2: Array is 16 by 16 pixels, addresses 00 through ff.
// RULE3: Gain loop steers shutter to keep brightest pixel in the mid fifties.
// RULE4: Shutter is 16-bit read-only cycles, two byte registers, resets to default.
// RULE5: Host reads upper shutter byte, then lower byte, nothing between.
// RULE6: Shutter moves at most one sixteenth of its value per frame; code cuts it to a lowered RULE7 cap in a single frame.
// RULE7: Shutter capped at frame period in cycles minus 2816.
// RULE8: Above 1500 fps host should adapt frame rate from shutter value.
// RULE9: Frame period is 16-bit two's complement RW, resets 0x20 and 0xd1.
// RULE10: Frame counter increments each system clock until it overflows.
// RULE11: Host programs two's complement of clock over frame rate.
// RULE12: Counter overflow starts a frame and reloads programmed period.
// RULE13: Upper shutter read captures lower byte for the following read.
module eft_exposure_frame_timing
    import eft_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    output logic                            reg_rvalid,
    input  wire logic                       pixel_valid,
    input  wire logic [PIXEL_BITS-1:0]      pixel_value,
    output logic                            pixel_out_valid,
    output logic      [PIXEL_ADDR_BITS-1:0] pixel_out_addr,
    output logic      [PIXEL_BITS-1:0]      pixel_out_value,
    output logic                            frame_start,
    output logic      [PIXEL_BITS-1:0]      frame_max_pixel,
    output logic      [15:0]                exposure_cycles
);

    eft_agc_if agc_bus ();

    logic [7:0]                 frame_length_low;
    logic [7:0]                 frame_length_high;
    logic [15:0]                frame_length_bits;
    logic [15:0]                frame_counter;
    logic                       overflow;
    logic [7:0]                 exposure_low_hold;
    logic                       exposure_low_held;
    logic [PIXEL_ADDR_BITS-1:0] pixel_addr;
    logic [PIXEL_BITS-1:0]      running_max;
    logic [16:0]                period_cycles;
    logic [16:0]                limit_wide;
    logic [7:0]                 next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Frame period register and counter

    assign frame_length_bits = {frame_length_high, frame_length_low};
    assign overflow          = (frame_counter == COUNTER_LAST); // RULE10

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_length_low  <= FRAME_LENGTH_LOW_RESET; // RULE9
            frame_length_high <= FRAME_LENGTH_HIGH_RESET; // RULE9
        end else if (ce && reg_wr) begin
            if (reg_addr == FRAME_LENGTH_LOW_ADDR) begin
                frame_length_low <= reg_wdata; // RULE9
            end else if (reg_addr == FRAME_LENGTH_HIGH_ADDR) begin
                frame_length_high <= reg_wdata; // RULE9
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_counter <= {FRAME_LENGTH_HIGH_RESET, FRAME_LENGTH_LOW_RESET};
        end else if (ce) begin
            if (overflow) begin
                frame_counter <= frame_length_bits; // RULE12
            end else begin
                frame_counter <= frame_counter + 16'h0001; // RULE10
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_start <= 1'b0;
        end else if (ce) begin
            frame_start <= overflow; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shutter ceiling: period in cycles minus fixed headroom

    assign period_cycles = 17'h10000 - {1'b0, frame_length_bits};
    assign limit_wide    = period_cycles - EXPOSURE_HEADROOM; // RULE7

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            agc_bus.shutter_limit <= 16'hffff;
        end else if (ce) begin
            if (period_cycles <= EXPOSURE_HEADROOM) begin
                agc_bus.shutter_limit <= 16'h0001; // RULE7
            end else if (limit_wide[16]) begin
                agc_bus.shutter_limit <= 16'hffff;
            end else begin
                agc_bus.shutter_limit <= limit_wide[15:0]; // RULE7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel intake: address walk and brightest pixel per frame

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pixel_addr <= PIXEL_ADDR_FIRST;
        end else if (ce) begin
            if (overflow) begin
                pixel_addr <= PIXEL_ADDR_FIRST; // RULE2
            end else if (pixel_valid && pixel_addr != PIXEL_ADDR_LAST) begin
                pixel_addr <= pixel_addr + 8'h01; // RULE2
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pixel_out_valid <= 1'b0;
            pixel_out_addr  <= PIXEL_ADDR_FIRST;
            pixel_out_value <= 6'h00;
        end else if (ce) begin
            pixel_out_valid <= pixel_valid;
            if (pixel_valid) begin
                pixel_out_addr  <= pixel_addr; // RULE2
                pixel_out_value <= pixel_value & PIXEL_WHITE; // RULE1
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            running_max <= 6'h00;
        end else if (ce) begin
            if (overflow) begin
                running_max <= 6'h00;
            end else if (pixel_valid && pixel_value > running_max) begin
                running_max <= pixel_value; // RULE3
            end
        end
    end

    // Hand the finished frame's brightest pixel to the gain loop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            agc_bus.frame_tick <= 1'b0;
            agc_bus.max_pixel  <= 6'h00;
            frame_max_pixel    <= 6'h00;
        end else if (ce) begin
            agc_bus.frame_tick <= overflow; // RULE3
            if (overflow) begin
                agc_bus.max_pixel <= running_max;
                frame_max_pixel   <= running_max;
            end
        end
    end

    eft_gain_loop u_gain_loop (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .agc     (agc_bus.agc)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            exposure_cycles <= EXPOSURE_RESET;
        end else if (ce) begin
            exposure_cycles <= agc_bus.shutter;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coherent shutter read: upper read freezes the lower byte

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            exposure_low_hold <= EXPOSURE_RESET[7:0];
            exposure_low_held <= 1'b0;
        end else if (ce) begin
            if (reg_rd && reg_addr == EXPOSURE_HIGH_ADDR) begin
                exposure_low_hold <= agc_bus.shutter[7:0]; // RULE13
                exposure_low_held <= 1'b1; // RULE13
            end else if (reg_rd && reg_addr == EXPOSURE_LOW_ADDR) begin
                exposure_low_held <= 1'b0; // RULE5
            end else if (!exposure_low_held) begin
                exposure_low_hold <= agc_bus.shutter[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == EXPOSURE_LOW_ADDR) begin
            next_rdata = exposure_low_held ? exposure_low_hold
                                           : agc_bus.shutter[7:0]; // RULE13
        end else if (reg_addr == EXPOSURE_HIGH_ADDR) begin
            next_rdata = agc_bus.shutter[15:8]; // RULE4
        end else if (reg_addr == FRAME_LENGTH_LOW_ADDR) begin
            next_rdata = frame_length_low;
        end else if (reg_addr == FRAME_LENGTH_HIGH_ADDR) begin
            next_rdata = frame_length_high;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule

// ### test/eft_sva.sv
`timescale 1ns/1ps
module eft_sva
    import eft_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        pixel_valid,
    input wire logic [5:0]  pixel_value,
    input wire logic        pixel_out_valid,
    input wire logic [7:0]  pixel_out_addr,
    input wire logic [5:0]  pixel_out_value,
    input wire logic        frame_start,
    input wire logic [5:0]  frame_max_pixel,
    input wire logic [15:0] exposure_cycles
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_answer: assert property (ce && !reg_rd |=> !reg_rvalid)
        else $error("spurious read answer");
    a_rdata_hold: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (ce && reg_rd &&
        (reg_addr < 8'h0e || reg_addr > 8'h11) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_start_pulse: assert property (ce && frame_start |=> !frame_start)
        else $error("frame start too long");
    a_pixel_echo: assert property (ce && pixel_valid |=>
        pixel_out_valid && pixel_out_value == $past(pixel_value))
        else $error("pixel not passed on");
    a_addr_restart: assert property (ce && pixel_valid && frame_start
        |=> pixel_out_addr == PIXEL_ADDR_FIRST)
        else $error("address not restarted");
    a_addr_step: assert property (ce && pixel_valid && pixel_out_valid &&
        !frame_start && pixel_out_addr != PIXEL_ADDR_LAST |=> frame_start ||
        pixel_out_addr == $past(pixel_out_addr) + 8'h01)
        else $error("address not stepped");
    a_shutter_rise: assert property (exposure_cycles <=
        {1'b0, $past(exposure_cycles)} + ($past(exposure_cycles) >> 4))
        else $error("shutter rose too fast");
    a_shutter_floor: assert property (exposure_cycles != 16'h0000)
        else $error("shutter at zero");

    c_frame: cover property (frame_start);
    c_pair: cover property (reg_rd && reg_addr == EXPOSURE_HIGH_ADDR
        ##[1:4] reg_rd && reg_addr == EXPOSURE_LOW_ADDR);
    c_last_pixel: cover property (pixel_out_valid && pixel_out_addr == 8'hff);
endmodule

bind eft_exposure_frame_timing eft_sva chk (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pixel_valid(pixel_valid), .pixel_value(pixel_value),
    .pixel_out_valid(pixel_out_valid), .pixel_out_addr(pixel_out_addr),
    .pixel_out_value(pixel_out_value), .frame_start(frame_start),
    .frame_max_pixel(frame_max_pixel), .exposure_cycles(exposure_cycles));

// ### test/eft_pix_src.sv
`timescale 1ns/1ps
module eft_pix_src
    import eft_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       frame_start,
    input  wire logic [5:0] level,
    output logic            pixel_valid,
    output logic      [5:0] pixel_value
);
    int left = 0;
    initial begin
        pixel_valid = 1'b0;
        pixel_value = 6'h00;
    end
    // Whole array after each frame start; idle value toggles
    always @(negedge clk_sys) begin
        if (frame_start) left = 256;
        pixel_valid <= (left > 0);
        pixel_value <= (left > 0) ? level : ~pixel_value;
        if (left > 0) left = left - 1;
    end
endmodule

// ### test/tb_exposure_frame_timing.sv
`timescale 1ns/1ps
module tb_exposure_frame_timing;
    import eft_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [5:0] level = 6'h10;
    logic [7:0] reg_rdata, pixel_out_addr, last_addr;
    logic [5:0] pixel_value, pixel_out_value, frame_max_pixel;
    logic [15:0] exposure_cycles;
    logic reg_rvalid, pixel_valid, pixel_out_valid, frame_start;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int last_fs = 0;
    int gap = 0;
    logic [15:0] prev_s = EXPOSURE_RESET;

    always #25 clk_sys = ~clk_sys;

    eft_exposure_frame_timing uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pixel_valid(pixel_valid), .pixel_value(pixel_value),
        .pixel_out_valid(pixel_out_valid), .pixel_out_addr(pixel_out_addr),
        .pixel_out_value(pixel_out_value), .frame_start(frame_start),
        .frame_max_pixel(frame_max_pixel), .exposure_cycles(exposure_cycles));
    eft_pix_src src (.clk_sys(clk_sys), .frame_start(frame_start),
        .level(level), .pixel_valid(pixel_valid), .pixel_value(pixel_value));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            close_out();
        end
    end
    always @(negedge clk_sys) begin
        if (pixel_out_valid) last_addr = pixel_out_addr;
        if (frame_start) begin
            gap = cyc - last_fs;
            last_fs = cyc;
        end
    end

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("rvalid", 16'h1, {15'h0, reg_rvalid});
        chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, reg_rdata});
    endtask
    // Frame results, shutter pair read, then next frame's level
    task automatic frame(input logic [5:0] m, input logic [15:0] s,
                         input int g, input logic [5:0] nl);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (frame_start !== 1'b1 && n < 20000);
        chk("frame seen", 16'h1, {15'h0, frame_start});
        // Pair read straddles the shutter update: old value must come back
        reg_addr = EXPOSURE_HIGH_ADDR;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        chk("held high", {8'h0, prev_s[15:8]}, {8'h0, reg_rdata});
        reg_addr = EXPOSURE_LOW_ADDR;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("held low", {8'h0, prev_s[7:0]}, {8'h0, reg_rdata});
        repeat (2) @(negedge clk_sys);
        chk("max", {10'h0, m}, {10'h0, frame_max_pixel});
        chk("shutter", s, exposure_cycles);
        if (g > 0) chk("period", g[15:0], gap[15:0]);
        rchk(EXPOSURE_HIGH_ADDR, s[15:8]);
        rchk(EXPOSURE_LOW_ADDR, s[7:0]);
        repeat (300) @(negedge clk_sys);
        chk("last addr", 16'hff, {8'h0, last_addr});
        level = nl;
        prev_s = s;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        rchk(8'h10, 8'h20);
        rchk(8'h11, 8'hd1);
        rchk(8'h0f, 8'h00);
        rchk(8'h0e, 8'h64);
        wr(8'h0e, 8'h55);
        rchk(8'h0e, 8'h64);
        rchk(8'h20, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'hf0);
        rchk(8'h10, 8'h00);
        rchk(8'h11, 8'hf0);
        // Clock enable low: write and read both ignored
        @(negedge clk_sys);
        ce = 1'b0;
        wr(8'h10, 8'h5a);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("frozen rvalid", 16'h0, {15'h0, reg_rvalid});
        chk("frozen rdata", 16'hf0, {8'h0, reg_rdata});
        ce = 1'b1;
        rchk(8'h10, 8'h00);
        frame(6'h00, 16'd106, 0, 6'h3f);
        frame(6'h10, 16'd112, 4096, 6'h36);
        frame(6'h3f, 16'd105, 4096, 6'h3f);
        frame(6'h36, 16'd105, 4096, 6'h10);
        frame(6'h3f, 16'd99, 4096, 6'h10);
        wr(8'h10, 8'hf0);
        wr(8'h11, 8'hf4);
        frame(6'h10, 16'd16, 4096, 6'h10);
        frame(6'h10, 16'd16, 2832, 6'h10);
        close_out();
    end
endmodule
